// ===== rtl/aic_cond.sv
// pressure analog input conditioning: unit, offset, alarms, safe state
// assumes parameter writes arrive decoded by id, one per cycle, on sys_clk
// values are signed fixed point raw_count_unit; float type is a tag passed through
`include "aic_map.svh"
module aic_cond #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// device state
	input wire logic running,
	input wire logic device_error,
	input wire logic maker_fault,
	input wire logic sensor_alarm,
	input wire logic cyclic_v0_active,
	// measurement and range from the transducer
	input wire logic signed [W-1:0] raw_meas,
	input wire logic signed [W-1:0] gain_q8,
	input wire logic signed [W-1:0] full_scale_in,
	input wire logic signed [W-1:0] over_in,
	input wire logic signed [W-1:0] under_in,
	// parameter access
	input wire aic_pkg::aic_wr_t wr_in,
	input wire logic [7:0] rd_id,
	// results
	output logic [31:0] rd_data,
	output logic wr_refused,
	output logic signed [W-1:0] conditioned_pressure_value,
	output logic reading_valid,
	output logic [7:0] status_bits,
	output logic [15:0] unit_all,
	output logic [7:0] type_all
);
	// ************************************************************
	// parameter storage
	// ************************************************************
	logic [15:0] unit_reg;
	logic [7:0] type_reg;
	logic [7:0] ofs_type_reg;
	logic signed [W-1:0] ofs_reg;
	logic alm_en_reg;
	logic wrn_en_reg;
	logic signed [W-1:0] atp_hi_reg, atp_lo_reg, ahys_reg;
	logic signed [W-1:0] wtp_hi_reg, wtp_lo_reg, whys_reg;
	aic_pkg::aic_safe_t safe_reg;
	logic signed [W-1:0] svalue_reg;
	logic [15:0] adjust_reg;
	logic signed [W-1:0] meas_pv, last_reg, pv_next;
	aic_pkg::aic_cond_t cond_reg;
	logic wr_unit, unit_ok, wr_adj, zero_go;

	function automatic logic unit_legal(input logic [15:0] u);
		unit_legal = (u == `AIC_UNIT_RAW) || (u == `AIC_UNIT_TORR) ||
			(u == `AIC_UNIT_MBAR) || (u == `AIC_UNIT_PA);
	endfunction

	function automatic logic type_legal(input logic [7:0] t);
		type_legal = (t == `AIC_TYPE_SIGNED_16BIT_TYPE) || (t == `AIC_TYPE_FLOAT);
	endfunction

	assign wr_unit = wr_in.wr && (wr_in.id == `AIC_ID_UNIT);
	// cyclic user data wins regardless of source history; acyclic needs idle
	assign unit_ok = unit_legal(wr_in.data[15:0]) && (wr_in.cyclic ||
		(!running && !cyclic_v0_active));
	assign wr_adj = wr_in.wr && (wr_in.id == `AIC_ID_ADJUST);
	assign zero_go = wr_adj && (wr_in.data[7:0] == `AIC_ADJ_ZERO) &&
		(wr_in.data[15:8] == `AIC_TGT_START);

	// ************************************************************
	// unit and type, held per instance and copied out on unit_all and type_all
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			unit_reg <= `AIC_UNIT_TORR;
			type_reg <= `AIC_TYPE_FLOAT;
			ofs_type_reg <= `AIC_TYPE_FLOAT;
		end else if (wr_in.wr) begin
			if (wr_unit && unit_ok) begin
				unit_reg <= wr_in.data[15:0];
			end
			if (wr_in.id == `AIC_ID_TYPE && type_legal(wr_in.data[7:0]) &&
				(wr_in.cyclic || !cyclic_v0_active)) begin
				type_reg <= wr_in.data[7:0];
			end
			if (wr_in.id == `AIC_ID_OFS_TYPE && type_legal(wr_in.data[7:0])) begin
				ofs_type_reg <= wr_in.data[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_refused <= 1'b0;
		end else begin
			wr_refused <= wr_unit && !unit_ok;
		end
	end

	// ************************************************************
	// trip points, enables, safe state
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alm_en_reg <= 1'b0;
			wrn_en_reg <= 1'b0;
			atp_hi_reg <= '0;
			atp_lo_reg <= '0;
			ahys_reg <= '0;
			wtp_hi_reg <= '0;
			wtp_lo_reg <= '0;
			whys_reg <= '0;
			safe_reg <= aic_pkg::AIC_SAFE_ZERO;
			svalue_reg <= '0;
		end else if (wr_in.wr) begin
			// range of trip values is the master's duty, stored as given
			case (wr_in.id)
				`AIC_ID_ALM_EN: alm_en_reg <= wr_in.data[0];
				`AIC_ID_WRN_EN: wrn_en_reg <= wr_in.data[0];
				`AIC_ID_ATP_HI: atp_hi_reg <= wr_in.data[W-1:0];
				`AIC_ID_ATP_LO: atp_lo_reg <= wr_in.data[W-1:0];
				`AIC_ID_AHYS: ahys_reg <= wr_in.data[W-1:0];
				`AIC_ID_WTP_HI: wtp_hi_reg <= wr_in.data[W-1:0];
				`AIC_ID_WTP_LO: wtp_lo_reg <= wr_in.data[W-1:0];
				`AIC_ID_WHYS: whys_reg <= wr_in.data[W-1:0];
				`AIC_ID_SSTATE: safe_reg <= aic_pkg::aic_safe_t'(wr_in.data[1:0]);
				// no unit conversion applied, so a zero stays zero
				`AIC_ID_SVALUE: svalue_reg <= wr_in.data[W-1:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// adjust command and offset
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			adjust_reg <= '0;
			ofs_reg <= '0;
		end else begin
			if (wr_adj) begin
				adjust_reg <= wr_in.data[15:0];
			end
			if (zero_go) begin
				ofs_reg <= -raw_meas;
			end else if (wr_in.wr && wr_in.id == `AIC_ID_OFS) begin
				ofs_reg <= wr_in.data[W-1:0];
			end
		end
	end

	// ************************************************************
	// process value
	// ************************************************************
	logic signed [2*W-1:0] prod;
	assign prod = (raw_meas + ofs_reg) * gain_q8;
	assign meas_pv = prod[W+7:8];

	always_comb begin
		pv_next = meas_pv;
		if (!running || device_error) begin
			case (safe_reg)
				aic_pkg::AIC_SAFE_ZERO: pv_next = '0;
				aic_pkg::AIC_SAFE_FULL: pv_next = full_scale_in;
				aic_pkg::AIC_SAFE_HOLD: pv_next = last_reg;
				aic_pkg::AIC_SAFE_VALUE: pv_next = svalue_reg;
				default: pv_next = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			last_reg <= '0;
			conditioned_pressure_value <= '0;
		end else begin
			if (running && !device_error) begin
				last_reg <= meas_pv;
			end
			conditioned_pressure_value <= pv_next;
		end
	end

	// ************************************************************
	// alarms and warnings with hysteresis
	// ************************************************************
	function automatic logic hi_next(input logic cur, input logic signed [W-1:0] v,
		input logic signed [W-1:0] tp, input logic signed [W-1:0] hy);
		hi_next = cur ? !(v < tp - hy) : (v > tp);
	endfunction

	function automatic logic lo_next(input logic cur, input logic signed [W-1:0] v,
		input logic signed [W-1:0] tp, input logic signed [W-1:0] hy);
		lo_next = cur ? !(v > tp + hy) : (v < tp);
	endfunction

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cond_reg <= '0;
		end else begin
			cond_reg.hi_alm <= alm_en_reg &&
				hi_next(cond_reg.hi_alm, pv_next, atp_hi_reg, ahys_reg);
			cond_reg.lo_alm <= alm_en_reg &&
				lo_next(cond_reg.lo_alm, pv_next, atp_lo_reg, ahys_reg);
			cond_reg.hi_wrn <= wrn_en_reg &&
				hi_next(cond_reg.hi_wrn, pv_next, wtp_hi_reg, whys_reg);
			cond_reg.lo_wrn <= wrn_en_reg &&
				lo_next(cond_reg.lo_wrn, pv_next, wtp_lo_reg, whys_reg);
		end
	end

	logic [7:0] status_next;
	always_comb begin
		status_next = '0;
		status_next[`AIC_BIT_HI_ALM] = cond_reg.hi_alm;
		status_next[`AIC_BIT_LO_ALM] = cond_reg.lo_alm;
		status_next[`AIC_BIT_HI_WRN] = cond_reg.hi_wrn;
		status_next[`AIC_BIT_LO_WRN] = cond_reg.lo_wrn;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status_bits <= '0;
			reading_valid <= 1'b0;
			unit_all <= `AIC_UNIT_TORR;
			type_all <= `AIC_TYPE_FLOAT;
		end else begin
			status_bits <= status_next;
			reading_valid <= running && !maker_fault && !sensor_alarm;
			unit_all <= unit_reg;
			type_all <= type_reg;
		end
	end

	// ************************************************************
	// parameter read back, one cycle latency
	// ************************************************************
	logic [31:0] rd_next;
	always_comb begin
		rd_next = '0;
		case (rd_id)
			`AIC_ID_ADJUST: rd_next = {16'h0000, adjust_reg};
			`AIC_ID_ALM_EN: rd_next = {31'h0, alm_en_reg};
			`AIC_ID_WRN_EN: rd_next = {31'h0, wrn_en_reg};
			`AIC_ID_PV: rd_next = 32'(conditioned_pressure_value);
			`AIC_ID_STATUS: rd_next = {24'h0, status_bits};
			`AIC_ID_TYPE: rd_next = {24'h0, type_reg};
			`AIC_ID_UNIT: rd_next = {16'h0, unit_reg};
			`AIC_ID_VALID: rd_next = {31'h0, reading_valid};
			`AIC_ID_FSCALE: rd_next = 32'(full_scale_in);
			`AIC_ID_OFS_TYPE: rd_next = {24'h0, ofs_type_reg};
			`AIC_ID_OFS: rd_next = 32'(ofs_reg);
			`AIC_ID_ATP_HI: rd_next = 32'(atp_hi_reg);
			`AIC_ID_ATP_LO: rd_next = 32'(atp_lo_reg);
			`AIC_ID_AHYS: rd_next = 32'(ahys_reg);
			`AIC_ID_WTP_HI: rd_next = 32'(wtp_hi_reg);
			`AIC_ID_WTP_LO: rd_next = 32'(wtp_lo_reg);
			`AIC_ID_WHYS: rd_next = 32'(whys_reg);
			`AIC_ID_SSTATE: rd_next = {30'h0, safe_reg};
			`AIC_ID_SVALUE: rd_next = 32'(svalue_reg);
			`AIC_ID_OVR: rd_next = 32'(over_in);
			`AIC_ID_UNR: rd_next = 32'(under_in);
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_next;
		end
	end
endmodule // aic_cond

// ===== rtl/aic_map.svh
// constants of the pressure input conditioning block
// assumes a fieldbus engine outside decodes parameter ids into writes
// Summary of operation
// - accept unit codes 1001 raw, 1301 Torr, 1308 mbar, 1309 Pascal
// - acyclic unit change refused during first generation cyclic exchange
// - acyclic unit change permitted only while idle
// - cyclic user parameter unit overwrites earlier acyclic unit
// - unit setting applies to every block instance; here each instance keeps its own unit_reg
// - reading valid only when running, no maker fault, no sensor alarm
// - full scale reported in current type and unit
// - offset added before gain; zero adjust rewrites offset
// - separate type parameter sets offset numeric representation
// - alarm when value rises above high alarm trip point
// - alarm when value falls below low alarm trip point
// - alarm clears only after recovering by alarm hysteresis
// - warning when value rises above high warning trip point
// - warning when value falls below low warning trip point
// - not running or device error outputs safe state value
// - safe state 0 zero, 1 full scale, 2 hold last, 3 safe value
// - zero safe value stays zero across unit changes
// - overrange reports highest valid value in current type and unit
// - underrange reports lowest valid value in current type and unit
// - adjust byte0 command, byte1 target; code 0 zero adjust
// - target 1 starts service; other targets do nothing
// - numeric type code 3 signed 16 bit, code 8 float
// - status bits set only when enables are 1; default disabled
`ifndef AIC_MAP_SVH
`define AIC_MAP_SVH
`define AIC_ID_ADJUST 8'h0F
`define AIC_ID_ALM_EN 8'h11
`define AIC_ID_WRN_EN 8'h12
`define AIC_ID_PV 8'h13
`define AIC_ID_STATUS 8'h14
`define AIC_ID_TYPE 8'h15
`define AIC_ID_UNIT 8'h16
`define AIC_ID_VALID 8'h17
`define AIC_ID_FSCALE 8'h18
`define AIC_ID_OFS_TYPE 8'h19
`define AIC_ID_OFS 8'h1A
`define AIC_ID_ATP_HI 8'h1F
`define AIC_ID_ATP_LO 8'h20
`define AIC_ID_AHYS 8'h21
`define AIC_ID_WTP_HI 8'h23
`define AIC_ID_WTP_LO 8'h24
`define AIC_ID_WHYS 8'h25
`define AIC_ID_SSTATE 8'h27
`define AIC_ID_SVALUE 8'h28
`define AIC_ID_OVR 8'h2C
`define AIC_ID_UNR 8'h2D
`define AIC_UNIT_RAW 16'h1001
`define AIC_UNIT_TORR 16'h1301
`define AIC_UNIT_MBAR 16'h1308
`define AIC_UNIT_PA 16'h1309
`define AIC_TYPE_SIGNED_16BIT_TYPE 8'h03
`define AIC_TYPE_FLOAT 8'h08
`define AIC_ADJ_ZERO 8'h00
`define AIC_TGT_START 8'h01
`define AIC_BIT_HI_ALM 0
`define AIC_BIT_LO_ALM 1
`define AIC_BIT_HI_WRN 2
`define AIC_BIT_LO_WRN 3
`endif

// ===== rtl/aic_pkg.sv
// types of the pressure input conditioning block
// assumes aic_map.svh is on the include path
package aic_pkg;
	typedef enum logic [1:0] {
		AIC_SAFE_ZERO,
		AIC_SAFE_FULL,
		AIC_SAFE_HOLD,
		AIC_SAFE_VALUE
	} aic_safe_t;
	typedef struct packed {
		logic wr;
		logic cyclic;
		logic [7:0] id;
		logic [31:0] data;
	} aic_wr_t;
	typedef struct packed {
		logic hi_alm;
		logic lo_alm;
		logic hi_wrn;
		logic lo_wrn;
	} aic_cond_t;
endpackage

// ===== dv/aic_master.sv
// fieldbus master model: turns bench requests into parameter writes
// assumes requests are driven by nba at the rising edge of sys_clk
module aic_master #(
	parameter int SV_MAX = 32'h0000_7FFF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// bench request
	input wire logic go,
	input wire logic cyc,
	input wire logic [7:0] id,
	input wire logic [31:0] data,
	// write toward the block
	output aic_pkg::aic_wr_t wr_out
);
	logic lim;
	// trip points and hysteresis never exceed SV_MAX; values below it pass unchanged
	assign lim = id inside {8'h1F, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25};
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_out <= '0;
		end else begin
			// unit in user data when cyclic; adjust started with target 1
			wr_out <= {go, cyc, id, (lim && $signed(data) > SV_MAX) ? SV_MAX : data};
		end
	end
endmodule // aic_master

// ===== dv/aic_cond_props.sv
// port checker for aic_cond, bound to the design
// assumes one clock and a synchronous active-high reset
module aic_cond_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// device state
	input wire logic running,
	input wire logic maker_fault,
	input wire logic sensor_alarm,
	input wire logic cyclic_v0_active,
	// parameter access
	input wire aic_pkg::aic_wr_t wr_in,
	input wire logic [7:0] rd_id,
	input wire logic [31:0] rd_data,
	input wire logic wr_refused,
	// results
	input wire logic reading_valid,
	input wire logic [15:0] unit_all,
	input wire logic [7:0] type_all
);
	// ********
	// properties
	// ********
	logic uw;
	logic uok;
	assign uw = wr_in.wr && wr_in.id == 8'h16;
	assign uok = wr_in.data[15:0] inside {16'h1001, 16'h1301, 16'h1308, 16'h1309};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	chk_unit_reset: assert property (disable iff (1'b0) reset |=> unit_all == 16'h1301)
		else $error("unit not at default after reset");
	chk_unit_bad: assert property (uw && !uok |=> wr_refused && $stable(unit_all))
		else $error("illegal unit code taken");
	chk_unit_idle: assert property (uw && !wr_in.cyclic && running |=> wr_refused)
		else $error("unit changed while not idle");
	chk_unit_v0: assert property (uw && !wr_in.cyclic && cyclic_v0_active |=> wr_refused)
		else $error("unit changed during cyclic exchange");
	chk_unit_cyclic: assert property (uw && wr_in.cyclic && uok |=> !wr_refused ##1 unit_all == $past(wr_in.data[15:0], 2))
		else $error("user parameter unit not applied");
	chk_unit_hold: assert property (!uw && !$past(uw) |=> $stable(unit_all) && !wr_refused)
		else $error("unit moved without a write");
	chk_valid_and: assert property (1'b1 |=> reading_valid == $past(running && !maker_fault && !sensor_alarm))
		else $error("reading valid wrong");
	chk_type_keep: assert property (wr_in.wr && wr_in.id == 8'h15 && (!(wr_in.data[7:0] inside {8'h03, 8'h08}) || cyclic_v0_active && !wr_in.cyclic) |=> ##1 $stable(type_all))
		else $error("type changed by refused write");
	chk_read_unit: assert property (rd_id == 8'h16 |=> rd_data[15:0] == $past(unit_all))
		else $error("unit readback wrong");
endmodule // aic_cond_props
bind aic_cond aic_cond_props i_aic_cond_props (.sys_clk(sys_clk), .reset(reset), .running(running),
	.maker_fault(maker_fault), .sensor_alarm(sensor_alarm), .cyclic_v0_active(cyclic_v0_active),
	.wr_in(wr_in), .rd_id(rd_id), .rd_data(rd_data), .wr_refused(wr_refused),
	.reading_valid(reading_valid), .unit_all(unit_all), .type_all(type_all));

// ===== dv/aic_cond_tb.sv
// self-checking bench for aic_cond with a master model on the write side
// assumes a 200 MHz clock; expectations follow the hand-over latencies
`define CK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module aic_cond_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic run, v0, cyc; logic [15:0] unit, exp; logic refd;} aic_row_t;
	logic sys_clk = 0, reset = 1, running = 0, device_error = 0, maker_fault = 0, sensor_alarm = 0;
	logic cyclic_v0_active = 0, go = 0, cyc = 0, wr_refused, reading_valid;
	logic signed [31:0] raw_meas = 0, gain_q8 = 32'h100, full_scale_in = 32'h3E8;
	logic signed [31:0] over_in = 32'h44C, under_in = -32'h32, conditioned_pressure_value;
	logic [7:0] wid = 0, rd_id = 0, status_bits, type_all;
	logic [31:0] wdat = 0, rd_data;
	logic [15:0] unit_all;
	aic_pkg::aic_wr_t wr_in;
	int fail_count = 0, checked = 0;
	aic_row_t rows [8] = '{{3'b000, 16'h1308, 16'h1308, 1'b0}, {3'b000, 16'h1309, 16'h1309, 1'b0},
		{3'b000, 16'h1001, 16'h1001, 1'b0}, {3'b000, 16'h1234, 16'h1001, 1'b1},
		{3'b100, 16'h1301, 16'h1001, 1'b1}, {3'b010, 16'h1301, 16'h1001, 1'b1},
		{3'b111, 16'h1301, 16'h1301, 1'b0}, {3'b001, 16'h1308, 16'h1308, 1'b0}};
	logic [39:0] stv [13] = '{{32'h12C, 8'h0}, {32'h191, 8'h4}, {32'h181, 8'h4}, {32'h17B, 8'h0},
		{32'h1F5, 8'h5}, {32'h1CC, 8'h5}, {32'h1C1, 8'h4}, {32'h12C, 8'h0}, {32'hC7, 8'h8},
		{32'h63, 8'hA}, {32'h8C, 8'hA}, {32'h97, 8'h8}, {32'hDD, 8'h0}};
	logic [31:0] sexp [4] = '{32'h0, 32'h3E8, 32'h12C, 32'h4D};
	logic [15:0] nop [3] = '{16'h0000, 16'h0200, 16'h0101};
	always #2.5 sys_clk = ~sys_clk;
	aic_master i_aic_master (.sys_clk(sys_clk), .reset(reset), .go(go), .cyc(cyc), .id(wid),
		.data(wdat), .wr_out(wr_in));
	aic_cond i_aic_cond (.sys_clk(sys_clk), .reset(reset), .running(running),
		.device_error(device_error), .maker_fault(maker_fault), .sensor_alarm(sensor_alarm),
		.cyclic_v0_active(cyclic_v0_active), .raw_meas(raw_meas), .gain_q8(gain_q8),
		.full_scale_in(full_scale_in), .over_in(over_in), .under_in(under_in), .wr_in(wr_in),
		.rd_id(rd_id), .rd_data(rd_data), .wr_refused(wr_refused),
		.conditioned_pressure_value(conditioned_pressure_value), .reading_valid(reading_valid),
		.status_bits(status_bits), .unit_all(unit_all), .type_all(type_all));
	// ********
	// tasks
	// ********
	task automatic w(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// ends one ns after the edge at which the block took the write
	task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic c);
		@(posedge sys_clk) {go, wid, wdat, cyc} <= {1'b1, i, d, c};
		@(posedge sys_clk) go <= 1'b0;
		w(1);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		@(posedge sys_clk) rd_id <= i;
		w(1);
		`CK(rd_data, e)
	endtask
	task automatic fin(input string n);
		$display("%s done, fails %0d", n, fail_count);
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		test_done();
	end
	// ********
	// tests
	// ********
	initial begin
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		w(1);
		`CK({unit_all, type_all, status_bits}, {16'h1301, 8'h08, 8'h00})
		foreach (rows[k]) begin
			@(posedge sys_clk) {running, cyclic_v0_active} <= {rows[k].run, rows[k].v0};
			wr(8'h16, {16'h0, rows[k].unit}, rows[k].cyc);
			`CK(wr_refused, rows[k].refd)
			w(1);
			`CK(unit_all, rows[k].exp)
		end
		fin("unit");
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk) {running, maker_fault, sensor_alarm} <= k[2:0];
			w(1);
			`CK(reading_valid, k == 4)
		end
		@(posedge sys_clk) {running, maker_fault, sensor_alarm, raw_meas} <= {3'b100, 32'h64};
		wr(8'h0F, 32'h100, 1'b0);
		w(1);
		`CK(conditioned_pressure_value, 32'h0)
		@(posedge sys_clk) {raw_meas, gain_q8} <= {32'h12C, 32'h200};
		w(1);
		`CK(conditioned_pressure_value, 32'h190)
		foreach (nop[k]) begin
			wr(8'h0F, {16'h0, nop[k]}, 1'b0);
			w(1);
			`CK(conditioned_pressure_value, 32'h190)
		end
		wr(8'h1A, 32'h0, 1'b0);
		@(posedge sys_clk) {raw_meas, gain_q8} <= {32'h258, 32'h100};
		fin("offset");
		wr(8'h1F, 32'h1F4, 1'b0);
		wr(8'h20, 32'h64, 1'b0);
		wr(8'h21, 32'h32, 1'b0);
		wr(8'h23, 32'h190, 1'b0);
		wr(8'h24, 32'hC8, 1'b0);
		wr(8'h25, 32'h14, 1'b0);
		`CK(status_bits, 8'h0)
		wr(8'h11, 32'h1, 1'b0);
		wr(8'h12, 32'h1, 1'b0);
		foreach (stv[k]) begin
			@(posedge sys_clk) raw_meas <= stv[k][39:8];
			w(2);
			`CK(status_bits, stv[k][7:0])
		end
		wr(8'h11, 32'h0, 1'b0);
		@(posedge sys_clk) raw_meas <= 32'h63;
		w(2);
		`CK(status_bits, 8'h8)
		@(posedge sys_clk) raw_meas <= 32'h12C;
		wr(8'h28, 32'h4D, 1'b0);
		fin("status");
		for (int s = 0; s < 4; s++) begin
			wr(8'h27, s, 1'b0);
			@(posedge sys_clk) running <= 1'b0;
			w(1);
			`CK(conditioned_pressure_value, sexp[s])
			@(posedge sys_clk) running <= 1'b1;
		end
		@(posedge sys_clk) device_error <= 1'b1;
		w(1);
		`CK(conditioned_pressure_value, 32'h4D)
		@(posedge sys_clk) {device_error, running} <= 2'b00;
		wr(8'h28, 32'h0, 1'b0);
		wr(8'h16, 32'h1309, 1'b0);
		w(1);
		`CK(conditioned_pressure_value, 32'h0)
		fin("safe");
		wr(8'h15, 32'h3, 1'b0);
		wr(8'h15, 32'h5, 1'b0);
		`CK(type_all, 8'h03)
		wr(8'h19, 32'h3, 1'b0);
		rd(8'h19, 32'h3);
		@(posedge sys_clk) cyclic_v0_active <= 1'b1;
		wr(8'h15, 32'h8, 1'b0);
		`CK(type_all, 8'h03)
		wr(8'h15, 32'h8, 1'b1);
		w(1);
		`CK(type_all, 8'h08)
		rd(8'h18, 32'h3E8);
		rd(8'h2C, 32'h44C);
		rd(8'h2D, -32'h32);
		rd(8'h16, 32'h1309);
		fin("type and read");
		@(posedge sys_clk) reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		w(1);
		`CK({unit_all, type_all, status_bits}, {16'h1301, 8'h08, 8'h00})
		fin("second reset");
		test_done();
	end
endmodule // aic_cond_tb
